// File: core/acs_pkg.sv
/*
  Shared constants and types of the calibration sequencer: device control word
  layout, calibration variants, phase timing, trim ranges and host register map.
  Assumes both ends and the link interface are compiled after this package.
*/
package acs_pkg;

  // Device control word carried over the link
  localparam int CTRL_W = 5;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SYS_BIT = 1;
  localparam int CTRL_VAR_LSB = 2;
  localparam int CTRL_BIPOLAR_BIT = 4;

  // Calibration variants
  localparam logic [1:0] VAR_FULL = 2'h0;
  localparam logic [1:0] VAR_GAIN_OFS = 2'h1;
  localparam logic [1:0] VAR_OFS = 2'h2;
  localparam logic [1:0] VAR_GAIN = 2'h3;

  // Level the host applies to the analog input
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_FULLSCALE = 2'h1;
  localparam logic [1:0] LVL_OFFSET = 2'h2;

  // Quantity being trimmed
  localparam logic [1:0] TGT_NONE = 2'h0;
  localparam logic [1:0] TGT_DAC = 2'h1;
  localparam logic [1:0] TGT_GAIN = 2'h2;
  localparam logic [1:0] TGT_OFS = 2'h3;

  // Calibration times, specified at the reference master clock
  localparam longint REF_CLK_KHZ = 6000;
  localparam longint CAL_FULL_NS = 41_700_000;
  localparam longint CAL_GAIN_OFS_NS = 9_260_000;
  localparam longint CAL_ONE_NS = 4_630_000;
  localparam int CAL_FULL_CYCLES = int'((CAL_FULL_NS * REF_CLK_KHZ) / 1_000_000);
  localparam int CAL_GAIN_OFS_CYCLES = int'((CAL_GAIN_OFS_NS * REF_CLK_KHZ) / 1_000_000);
  localparam int CAL_ONE_CYCLES = int'((CAL_ONE_NS * REF_CLK_KHZ) / 1_000_000);
  localparam int CAL_DAC_CYCLES = CAL_FULL_CYCLES - CAL_GAIN_OFS_CYCLES;
  localparam int TIMER_W = 18;
  localparam int TRIM_TICK_BITS = 8;

  // Host side timing at the 25 MHz system clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETUP_NS = 100;
  localparam int POWERUP_NS = 5000;
  localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_LOW_CYCLES = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HCNT_W = 8;

  // Trim registers
  localparam int TRIM_W = 8;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [7:0] TRIM_MAX = 8'hff;
  localparam logic [7:0] TRIM_MIN = 8'h00;
  localparam logic [7:0] TRIM_ONE = 8'h01;

  // Host register map (byte addresses)
  localparam int ADDR_W = 4;
  localparam logic [3:0] HOST_CTRL_ADDR = 4'h0;
  localparam logic [3:0] HOST_STAT_ADDR = 4'h4;
  localparam int HC_GO_BIT = 0;
  localparam int HC_SW_BIT = 1;
  localparam int HC_SYS_BIT = 2;
  localparam int HC_VAR_LSB = 3;
  localparam int HC_BIPOLAR_BIT = 5;
  localparam int HC_RUNS_LSB = 6;
  localparam int HS_BUSY_BIT = 0;
  localparam int HS_ACTIVE_BIT = 1;
  localparam int HS_DONE_BIT = 2;

  typedef enum logic [2:0]
  {
    D_IDLE = 3'h0,
    D_DAC = 3'h1,
    D_GAIN = 3'h3,
    D_OFS = 3'h2,
    D_WAIT_SS = 3'h6
  } acs_dev_state_type;

  typedef enum logic [3:0]
  {
    H_IDLE = 4'h0,
    H_CFG = 4'h1,
    H_CAL_LOW = 4'h3,
    H_WAIT_HI = 4'h2,
    H_WAIT_LO = 4'h6,
    H_OFS_SETUP = 4'h7,
    H_SS_LOW = 4'h5,
    H_WAIT_HI2 = 4'h4,
    H_WAIT_LO2 = 4'hc
  } acs_host_state_type;

  // Saturating one-step trim move; top bit flags a trim range limit
  function automatic logic [8:0] acs_trim_step(input logic [7:0] v, input logic up);
    logic [7:0] n;
    if (up)
    begin
      n = (v == TRIM_MAX) ? v : v + TRIM_ONE;
    end
    else
    begin
      n = (v == TRIM_MIN) ? v : v - TRIM_ONE;
    end
    return {(n == TRIM_MAX) || (n == TRIM_MIN), n};
  endfunction : acs_trim_step

endpackage : acs_pkg

// File: core/acs_if.sv
/*
  Link between the host processor end and the converter's calibration end.
  Assumes both ends run on the same clock; all signals are plain levels.
*/
`timescale 1ns/10ps
`default_nettype none
interface acs_if;
  logic cal_n;
  logic sample_start_n;
  logic ctrl_wr;
  logic [4:0] ctrl_data;
  logic [1:0] analog_input;
  logic busy;

  modport dev
  (
    input cal_n,
    input sample_start_n,
    input ctrl_wr,
    input ctrl_data,
    input analog_input,
    output busy
  );

  modport host
  (
    output cal_n,
    output sample_start_n,
    output ctrl_wr,
    output ctrl_data,
    output analog_input,
    input busy
  );
endinterface : acs_if
`default_nettype wire

// File: core/acs_phase_timer.sv
/*
  Phase down-counter of the calibration end: loads a phase length, signals
  the last cycle and a periodic trim tick. Assumes load is a single-cycle pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_phase_timer
(
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Phase load
  input wire logic load_in,
  input wire logic [17:0] len_in,
  // Status
  output logic done_out,
  output logic tick_out
);
  typedef struct packed
  {
    logic [17:0] cnt;
  } acs_tmr_regs_type;

  localparam logic [17:0] TIMER_ONE = 18'h00001;

  acs_tmr_regs_type r;
  acs_tmr_regs_type next_r;

  always_comb
  begin
    next_r = r;
    if (load_in)
    begin
      next_r.cnt = len_in;
    end
    else if (r.cnt != '0)
    begin
      next_r.cnt = r.cnt - TIMER_ONE;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
    end
    else if (ce_in)
    begin
      r <= next_r;
    end
  end

  assign done_out = (r.cnt == TIMER_ONE);
  assign tick_out = (r.cnt != '0) && (r.cnt[acs_pkg::TRIM_TICK_BITS-1:0] == '0);
endmodule : acs_phase_timer
`default_nettype wire

// File: core/acs_device.sv
/*
  Calibration sequencer of the converter end: starts on the calibration pin
  or a control write, runs the DAC, gain and offset trim phases, and reports
  busy over the link. Assumes the host keeps its timing on the link.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_device #(
  parameter int DAC_CYCLES = acs_pkg::CAL_DAC_CYCLES,
  parameter int TRIM_CYCLES = acs_pkg::CAL_ONE_CYCLES
)
(
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Link to the host
  acs_if.dev link,
  // Comparator from the analog core
  input wire logic err_high_in,
  // Trim results and status
  output logic [7:0] dac_trim_out,
  output logic [7:0] offset_trim_out,
  output logic [7:0] gain_trim_out,
  output logic [1:0] trim_target_out,
  output logic midscale_target_out,
  output logic trim_limit_out,
  output logic cal_done_out
);
  typedef struct packed
  {
    acs_pkg::acs_dev_state_type state;
    logic busy;
    logic cal_prev;
    logic ss_prev;
    logic sys;
    logic [1:0] variant;
    logic bipolar;
    logic [7:0] dac_trim;
    logic [7:0] ofs_trim;
    logic [7:0] gain_trim;
    logic at_limit;
    logic load;
    logic [17:0] load_len;
    logic done;
    logic [1:0] target;
  } acs_dev_regs_type;

  localparam logic [17:0] DAC_LEN = 18'(DAC_CYCLES);
  localparam logic [17:0] TRIM_LEN = 18'(TRIM_CYCLES);

  acs_dev_regs_type r;
  acs_dev_regs_type next_r;
  logic timer_done;
  logic timer_tick;
  logic cal_rise;
  logic ss_rise;
  logic sw_start;
  logic start_sys;
  logic [1:0] start_var;
  logic [8:0] step;

  // DAC trim is far longer, which makes the full variant the slow one
  function automatic logic [17:0] phase_len(input acs_pkg::acs_dev_state_type s);
    return (s == acs_pkg::D_DAC) ? DAC_LEN : TRIM_LEN;
  endfunction : phase_len

  function automatic acs_dev_regs_type enter(input acs_dev_regs_type v, input acs_pkg::acs_dev_state_type s);
    v.state = s;
    v.busy = 1'b1;
    v.load = 1'b1;
    v.load_len = phase_len(s);
    return v;
  endfunction : enter

  function automatic acs_pkg::acs_dev_state_type first_phase(input logic [1:0] var_sel);
    acs_pkg::acs_dev_state_type s;
    unique case (var_sel)
      acs_pkg::VAR_FULL: s = acs_pkg::D_DAC;
      acs_pkg::VAR_OFS: s = acs_pkg::D_OFS;
      default: s = acs_pkg::D_GAIN;
    endcase
    return s;
  endfunction : first_phase

  function automatic logic [1:0] target_of(input acs_pkg::acs_dev_state_type s);
    logic [1:0] t;
    unique case (s)
      acs_pkg::D_DAC: t = acs_pkg::TGT_DAC;
      acs_pkg::D_GAIN: t = acs_pkg::TGT_GAIN;
      acs_pkg::D_OFS: t = acs_pkg::TGT_OFS;
      default: t = acs_pkg::TGT_NONE;
    endcase
    return t;
  endfunction : target_of

  acs_phase_timer u_timer
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .load_in(r.load),
    .len_in(r.load_len),
    .done_out(timer_done),
    .tick_out(timer_tick)
  );

  always_comb
  begin
    next_r = r;
    next_r.load = 1'b0;
    next_r.done = 1'b0;
    next_r.cal_prev = link.cal_n;
    next_r.ss_prev = link.sample_start_n;
    cal_rise = link.cal_n && !r.cal_prev;
    ss_rise = link.sample_start_n && !r.ss_prev;
    sw_start = link.ctrl_wr && link.ctrl_data[acs_pkg::CTRL_START_BIT];
    start_sys = link.ctrl_wr ? link.ctrl_data[acs_pkg::CTRL_SYS_BIT] : r.sys;
    start_var = link.ctrl_wr ? link.ctrl_data[acs_pkg::CTRL_VAR_LSB +: 2] : r.variant;
    step = '0;
    // Mode writes and all start sources are locked out while busy
    if (!r.busy)
    begin
      if (link.ctrl_wr)
      begin
        next_r.sys = link.ctrl_data[acs_pkg::CTRL_SYS_BIT];
        next_r.variant = link.ctrl_data[acs_pkg::CTRL_VAR_LSB +: 2];
        next_r.bipolar = link.ctrl_data[acs_pkg::CTRL_BIPOLAR_BIT];
      end
      if (!link.cal_n)
      begin
        next_r.state = acs_pkg::D_IDLE;
      end
      else if (cal_rise || sw_start)
      begin
        next_r = enter(next_r, first_phase(start_var));
        next_r.sys = start_sys;
        next_r.variant = start_var;
        next_r.at_limit = 1'b0;
      end
      else if ((r.state == acs_pkg::D_WAIT_SS) && ss_rise)
      begin
        next_r = enter(next_r, acs_pkg::D_OFS);
      end
    end
    else
    begin
      if (timer_tick)
      begin
        unique case (r.state)
          acs_pkg::D_DAC:
          begin
            step = acs_pkg::acs_trim_step(r.dac_trim, !err_high_in);
            next_r.dac_trim = step[7:0];
          end
          acs_pkg::D_GAIN:
          begin
            step = acs_pkg::acs_trim_step(r.gain_trim, !err_high_in);
            next_r.gain_trim = step[7:0];
          end
          acs_pkg::D_OFS:
          begin
            step = acs_pkg::acs_trim_step(r.ofs_trim, !err_high_in);
            next_r.ofs_trim = step[7:0];
          end
          default:
          begin
            step = '0;
          end
        endcase
        // Saturation is only flagged; the phase still runs its full length
        next_r.at_limit = r.at_limit || step[8];
      end
      if (timer_done)
      begin
        unique case (r.state)
          acs_pkg::D_DAC:
          begin
            next_r = enter(next_r, acs_pkg::D_GAIN);
          end
          acs_pkg::D_GAIN:
          begin
            if ((r.variant == acs_pkg::VAR_FULL) || (r.variant == acs_pkg::VAR_GAIN_OFS))
            begin
              if (r.sys)
              begin
                next_r.state = acs_pkg::D_WAIT_SS;
                next_r.busy = 1'b0;
              end
              else
              begin
                next_r = enter(next_r, acs_pkg::D_OFS);
              end
            end
            else
            begin
              next_r.state = acs_pkg::D_IDLE;
              next_r.busy = 1'b0;
              next_r.done = 1'b1;
            end
          end
          acs_pkg::D_OFS:
          begin
            next_r.state = acs_pkg::D_IDLE;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
          end
          default:
          begin
            next_r.state = acs_pkg::D_IDLE;
            next_r.busy = 1'b0;
          end
        endcase
      end
    end
    next_r.target = target_of(next_r.state);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      r <= '{state: acs_pkg::D_IDLE, cal_prev: 1'b1, ss_prev: 1'b1, dac_trim: acs_pkg::TRIM_RESET,
             ofs_trim: acs_pkg::TRIM_RESET, gain_trim: acs_pkg::TRIM_RESET, default: '0};
    end
    else if (ce_in)
    begin
      r <= next_r;
    end
  end

  assign link.busy = r.busy;
  assign dac_trim_out = r.dac_trim;
  assign offset_trim_out = r.ofs_trim;
  assign gain_trim_out = r.gain_trim;
  assign trim_target_out = r.target;
  assign midscale_target_out = r.bipolar;
  assign trim_limit_out = r.at_limit;
  assign cal_done_out = r.done;
endmodule : acs_device
`default_nettype wire

// File: core/acs_host.sv
/*
  Host end: an Avalon-MM slave with waitrequest takes calibration orders and
  drives the calibration pin, sample-start, control writes and input level.
  Assumes the converter end answers busy over the shared link.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_host
(
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Link to the converter
  acs_if.host link
);
  typedef struct packed
  {
    acs_pkg::acs_host_state_type state;
    logic wreq;
    logic [31:0] rdata;
    logic sw;
    logic sys;
    logic [1:0] variant;
    logic bipolar;
    logic [1:0] runs;
    logic [1:0] runs_left;
    logic done;
    logic cal_n;
    logic ss_n;
    logic ctrl_wr;
    logic [4:0] ctrl_data;
    logic [1:0] level;
    logic [7:0] cnt;
  } acs_host_regs_type;

  localparam logic [7:0] SETUP_LEN = 8'(acs_pkg::SETUP_CYCLES);
  localparam logic [7:0] CAL_LOW_LEN = 8'(acs_pkg::CAL_LOW_CYCLES);
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [1:0] RUN_ONE = 2'h1;

  acs_host_regs_type r;
  acs_host_regs_type next_r;
  logic two_phase;

  always_comb
  begin
    next_r = r;
    two_phase = r.sys && ((r.variant == acs_pkg::VAR_FULL) || (r.variant == acs_pkg::VAR_GAIN_OFS));
    // Bus slave: one wait cycle, then the access takes effect
    if (r.wreq)
    begin
      if (avs_read_in || avs_write_in)
      begin
        next_r.wreq = 1'b0;
        next_r.rdata = '0;
        if (avs_read_in && (avs_address_in == acs_pkg::HOST_CTRL_ADDR))
        begin
          next_r.rdata[acs_pkg::HC_SW_BIT] = r.sw;
          next_r.rdata[acs_pkg::HC_SYS_BIT] = r.sys;
          next_r.rdata[acs_pkg::HC_VAR_LSB +: 2] = r.variant;
          next_r.rdata[acs_pkg::HC_BIPOLAR_BIT] = r.bipolar;
          next_r.rdata[acs_pkg::HC_RUNS_LSB +: 2] = r.runs;
        end
        else if (avs_read_in && (avs_address_in == acs_pkg::HOST_STAT_ADDR))
        begin
          next_r.rdata[acs_pkg::HS_BUSY_BIT] = link.busy;
          next_r.rdata[acs_pkg::HS_ACTIVE_BIT] = (r.state != acs_pkg::H_IDLE);
          next_r.rdata[acs_pkg::HS_DONE_BIT] = r.done;
        end
      end
    end
    else
    begin
      next_r.wreq = 1'b1;
      if (avs_write_in && (avs_address_in == acs_pkg::HOST_CTRL_ADDR) && (r.state == acs_pkg::H_IDLE))
      begin
        next_r.sw = avs_writedata_in[acs_pkg::HC_SW_BIT];
        next_r.sys = avs_writedata_in[acs_pkg::HC_SYS_BIT];
        next_r.variant = avs_writedata_in[acs_pkg::HC_VAR_LSB +: 2];
        next_r.bipolar = avs_writedata_in[acs_pkg::HC_BIPOLAR_BIT];
        // Two-bit field caps repeats at three, so at most four runs in all
        next_r.runs = avs_writedata_in[acs_pkg::HC_RUNS_LSB +: 2];
        if (avs_writedata_in[acs_pkg::HC_GO_BIT])
        begin
          next_r.runs_left = avs_writedata_in[acs_pkg::HC_RUNS_LSB +: 2];
          next_r.state = acs_pkg::H_CFG;
          next_r.cnt = SETUP_LEN;
        end
      end
      else if (avs_write_in && (avs_address_in == acs_pkg::HOST_STAT_ADDR) && avs_writedata_in[acs_pkg::HS_DONE_BIT])
      begin
        next_r.done = 1'b0;
      end
    end
    // Sequencer
    next_r.ctrl_wr = 1'b0;
    unique case (r.state)
      acs_pkg::H_IDLE:
      begin
        next_r.level = acs_pkg::LVL_NONE;
      end
      acs_pkg::H_CFG:
      begin
        next_r.level = !r.sys ? acs_pkg::LVL_NONE :
                       (r.variant == acs_pkg::VAR_OFS) ? acs_pkg::LVL_OFFSET : acs_pkg::LVL_FULLSCALE;
        if (r.cnt <= CNT_ONE)
        begin
          next_r.ctrl_wr = 1'b1;
          next_r.ctrl_data = {r.bipolar, r.variant, r.sys, r.sw};
          if (r.sw)
          begin
            next_r.state = acs_pkg::H_WAIT_HI;
          end
          else
          begin
            next_r.cal_n = 1'b0;
            next_r.cnt = CAL_LOW_LEN;
            next_r.state = acs_pkg::H_CAL_LOW;
          end
        end
        else
        begin
          next_r.cnt = r.cnt - CNT_ONE;
        end
      end
      acs_pkg::H_CAL_LOW:
      begin
        if (r.cnt <= CNT_ONE)
        begin
          next_r.cal_n = 1'b1;
          next_r.state = acs_pkg::H_WAIT_HI;
        end
        else
        begin
          next_r.cnt = r.cnt - CNT_ONE;
        end
      end
      acs_pkg::H_WAIT_HI:
      begin
        if (link.busy)
        begin
          next_r.state = acs_pkg::H_WAIT_LO;
        end
      end
      acs_pkg::H_WAIT_LO:
      begin
        if (!link.busy && two_phase)
        begin
          // Pin sample-start even on a software start: no mid-sequence write
          next_r.level = acs_pkg::LVL_OFFSET;
          next_r.cnt = SETUP_LEN;
          next_r.state = acs_pkg::H_OFS_SETUP;
        end
        else if (!link.busy)
        begin
          next_r.state = acs_pkg::H_WAIT_LO2;
        end
      end
      acs_pkg::H_OFS_SETUP:
      begin
        if (r.cnt <= CNT_ONE)
        begin
          next_r.ss_n = 1'b0;
          next_r.state = acs_pkg::H_SS_LOW;
        end
        else
        begin
          next_r.cnt = r.cnt - CNT_ONE;
        end
      end
      acs_pkg::H_SS_LOW:
      begin
        next_r.ss_n = 1'b1;
        next_r.state = acs_pkg::H_WAIT_HI2;
      end
      acs_pkg::H_WAIT_HI2:
      begin
        if (link.busy)
        begin
          next_r.state = acs_pkg::H_WAIT_LO2;
        end
      end
      acs_pkg::H_WAIT_LO2:
      begin
        if (!link.busy)
        begin
          next_r.level = acs_pkg::LVL_NONE;
          if (r.runs_left != '0)
          begin
            // Repeat the run so interacting offset and gain errors converge
            next_r.runs_left = r.runs_left - RUN_ONE;
            next_r.cnt = SETUP_LEN;
            next_r.state = acs_pkg::H_CFG;
          end
          else
          begin
            next_r.done = 1'b1;
            next_r.state = acs_pkg::H_IDLE;
          end
        end
      end
      default:
      begin
        next_r.state = acs_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      r <= '{state: acs_pkg::H_IDLE, wreq: 1'b1, cal_n: 1'b1, ss_n: 1'b1, default: '0};
    end
    else if (ce_in)
    begin
      r <= next_r;
    end
  end

  assign avs_readdata_out = r.rdata;
  assign avs_waitrequest_out = r.wreq;
  assign link.cal_n = r.cal_n;
  assign link.sample_start_n = r.ss_n;
  assign link.ctrl_wr = r.ctrl_wr;
  assign link.ctrl_data = r.ctrl_data;
  assign link.analog_input = r.level;
endmodule : acs_host
`default_nettype wire

// File: tb/acs_properties.sv
/*
  Checker on the calibration link between host and converter ends.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_properties #(
  parameter int DAC_CYCLES = 300,
  parameter int TRIM_CYCLES = 40
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Link signals
  input wire logic cal_n,
  input wire logic sample_start_n,
  input wire logic ctrl_wr,
  input wire logic [4:0] ctrl_data,
  input wire logic [1:0] analog_input,
  input wire logic busy
);
  logic [9:0] bcnt;
  logic [7:0] lcnt;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Run lengths of busy and of the low pin pulse
  always_ff @(posedge clk_in)
  begin
    bcnt <= (!rst_n_in || !busy) ? 10'h000 : bcnt + 10'h001;
    lcnt <= (!rst_n_in || cal_n) ? 8'h00 : ((lcnt == 8'hff) ? lcnt : lcnt + 8'h01);
  end
  chk_pin_busy: assert property ($rose(cal_n) && !busy |=> busy)
    else $error("busy not raised after pin rise");
  chk_sw_busy: assert property (ctrl_wr && ctrl_data[0] && !busy |=> busy)
    else $error("busy not raised after start write");
  chk_busy_min: assert property ($fell(busy) |-> bcnt >= TRIM_CYCLES)
    else $error("busy phase too short");
  chk_busy_max: assert property ($fell(busy) |-> bcnt <= DAC_CYCLES + 3 * TRIM_CYCLES + 8)
    else $error("busy phase too long");
  chk_input_held: assert property (busy && $past(busy) |-> $stable(analog_input))
    else $error("input level moved while busy");
  chk_offset_setup: assert property ($rose(sample_start_n) |-> analog_input == acs_pkg::LVL_OFFSET
    && $past(analog_input, 3) == acs_pkg::LVL_OFFSET)
    else $error("offset level not settled");
  chk_ss_busy: assert property ($rose(sample_start_n) && !busy |=> busy)
    else $error("busy not raised by sample start");
  chk_cal_low: assert property ($rose(cal_n) |-> lcnt >= acs_pkg::CAL_LOW_CYCLES)
    else $error("pin low pulse too short");
  chk_pin_setup: assert property ($rose(cal_n) |-> $past(analog_input, 3) == analog_input)
    else $error("input not settled before pin rise");
  chk_wr_pulse: assert property (ctrl_wr |=> !ctrl_wr)
    else $error("control write longer than one cycle");
  cover property ($rose(sample_start_n));
  cover property ($fell(busy) && bcnt > DAC_CYCLES);
  cover property (ctrl_wr && ctrl_data[0]);
endmodule : acs_properties
`default_nettype wire

// File: tb/tb.sv
/*
  Bench joining host and converter ends over the link.
  Assumes the package, the link and both ends compile first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  localparam int DAC_N = 300;
  localparam int TRIM_N = 40;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [31:0] rdata;
  logic [31:0] rnd = 32'h922148b7;
  logic waitreq;
  logic err_high = 1'b0;
  logic mid;
  logic prev = 1'b0;
  logic [7:0] dac_t;
  logic [7:0] ofs_t;
  logic [7:0] gain_t;
  logic [1:0] tgt;
  logic lim;
  logic done_p;
  int bad_count = 0;
  int comparisons = 0;
  int bt = 0;
  int rises = 0;
  int dones = 0;
  acs_if link_if();
  always #20 clk_in = ~clk_in;
  acs_host acs_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .link(link_if.host));
  acs_device #(.DAC_CYCLES(DAC_N), .TRIM_CYCLES(TRIM_N)) acs_device_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .ce_in(1'b1), .link(link_if.dev), .err_high_in(err_high), .dac_trim_out(dac_t),
    .offset_trim_out(ofs_t), .gain_trim_out(gain_t), .trim_target_out(tgt), .midscale_target_out(mid),
    .trim_limit_out(lim), .cal_done_out(done_p));
  acs_properties #(.DAC_CYCLES(DAC_N), .TRIM_CYCLES(TRIM_N)) acs_properties_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .cal_n(link_if.cal_n), .sample_start_n(link_if.sample_start_n),
    .ctrl_wr(link_if.ctrl_wr), .ctrl_data(link_if.ctrl_data), .analog_input(link_if.analog_input),
    .busy(link_if.busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Busy cycles per variant; hand-off cycles allowed as slack
  function automatic int exp_busy(input logic [1:0] v);
    return (v == acs_pkg::VAR_FULL) ? DAC_N + 2 * TRIM_N : ((v == acs_pkg::VAR_GAIN_OFS) ? 2 * TRIM_N : TRIM_N);
  endfunction : exp_busy
  always @(posedge clk_in)
  begin
    rnd <= lfsr(rnd);
    err_high <= rnd[0];
    bt += (link_if.busy === 1'b1);
    rises += (link_if.busy === 1'b1 && prev !== 1'b1);
    dones += (done_p === 1'b1);
    prev = link_if.busy;
    if (rst_n_in === 1'b1)
      `CHK(tgt != acs_pkg::TGT_NONE, link_if.busy === 1'b1)
  end
  task automatic report_and_stop;
    $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Held until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_in);
    if (n >= 20)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : bus
  initial
  begin
    int b0;
    int r0;
    int e;
    int k;
    int n;
    int dn0;
    logic [7:0] d0;
    logic [1:0] v;
    logic b;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    `CHK(waitreq, 1'b1)
    `CHK({dac_t, ofs_t, gain_t}, {3{acs_pkg::TRIM_RESET}})
    `CHK(tgt, acs_pkg::TGT_NONE)
    bus(1'b0, 4'h8, 32'h0);
    `CHK(q, 32'h0)
    // Every variant, self and system, pin and write start; last one runs twice
    for (int i = 0; i < 17; i++)
    begin
      v = (i == 16) ? acs_pkg::VAR_OFS : i[1:0];
      k = (i == 16) ? 2 : 1;
      b = rnd[5];
      b0 = bt;
      r0 = rises;
      dn0 = dones;
      d0 = dac_t;
      bus(1'b1, acs_pkg::HOST_CTRL_ADDR, {24'h0, 1'b0, i[4], b, v, i[3], i[2], 1'b1});
      bus(1'b1, acs_pkg::HOST_CTRL_ADDR, 32'h19);
      bus(1'b0, acs_pkg::HOST_CTRL_ADDR, 32'h0);
      `CHK(q, {24'h0, 1'b0, i[4], b, v, i[3], i[2], 1'b0})
      n = 0;
      do
      begin
        bus(1'b0, acs_pkg::HOST_STAT_ADDR, 32'h0);
        n++;
      end
      while (q[acs_pkg::HS_DONE_BIT] !== 1'b1 && n < 3000);
      if (n >= 3000)
      begin
        bad_count++;
        report_and_stop();
      end
      e = exp_busy(v) * k;
      k = (i[3] && v < 2'h2) ? 2 * k : k;
      `CHK(rises - r0, k)
      `CHK(bt - b0 >= e && bt - b0 <= e + 8, 1'b1)
      `CHK(q[2:0], 3'h4)
      `CHK(mid, b)
      `CHK(dones - dn0, (i == 16) ? 2 : 1)
      `CHK((dac_t == d0 + 8'h01) || (dac_t == d0 - 8'h01), v == acs_pkg::VAR_FULL)
      `CHK(lim, 1'b0)
      bus(1'b1, acs_pkg::HOST_STAT_ADDR, 32'h4);
    end
    // Reset in mid-calibration returns both ends to idle
    bus(1'b1, acs_pkg::HOST_CTRL_ADDR, 32'h1);
    repeat (200) @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    `CHK({waitreq, link_if.busy, link_if.cal_n, tgt}, 5'h14)
    `CHK({dac_t, ofs_t, gain_t}, {3{acs_pkg::TRIM_RESET}})
    bus(1'b0, acs_pkg::HOST_STAT_ADDR, 32'h0);
    `CHK(q, 32'h0)
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
